// ---- src/ppu_defs.vh ----
// Register offsets, reset values and field positions of the pattern unit
`ifndef PPU_DEFS_VH
`define PPU_DEFS_VH
// Byte addresses on the APB (low 16 bits of the address)
`define PPU_OFF_PEND_HIGH 16'hffa4
`define PPU_OFF_PEND_LOW 16'hffa5
`define PPU_OFF_PEND_G2 16'hffa6
`define PPU_OFF_PEND_G0 16'hffa7
`define PPU_OFF_EN_HIGH 16'hffa2
`define PPU_OFF_EN_LOW 16'hffa3
`define PPU_OFF_TRIG_SEL 16'hffa1
`define PPU_OFF_PORT_A 16'hffd3
`define PPU_OFF_PORT_B 16'hffd6
// Reset values
`define PPU_RST_PEND 8'h00
`define PPU_RST_EN 8'h00
`define PPU_RST_PORT 8'h00
`define PPU_RST_TRIG_SEL 8'hff
// Value of reserved bits and empty addresses
`define PPU_RSVD_BYTE 8'hff
// Trigger select field positions, two bits per group
`define PPU_SEL_G0_LSB 0
`define PPU_SEL_G1_LSB 2
`define PPU_SEL_G2_LSB 4
`define PPU_SEL_G3_LSB 6
`endif

// ---- src/ppu_pattern_transfer.v ----
// Next-data staging and compare-match transfer of the pulse pattern unit
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "ppu_defs.vh"
// Operation
// [R1] Port B output value is 8 bits, resets to zero, serves groups 2 and 3.
// [R2] Port B bits enabled for transfer ignore software writes, stay readable.
// [R3] Pending low byte is 8-bit R/W: upper nibble group 1, lower group 0.
// [R4] Pending high byte is 8-bit R/W: upper nibble group 3, lower group 2.
// [R5] Pending and enable registers clear on reset/hardware standby, not soft.
// [R6] Groups 0,1 same trigger: all bits at 0xffa5, 0xffa7 reads ones.
// [R7] Groups 0,1 differ: group 1 at 0xffa5 high, group 0 at 0xffa7 low.
// [R8] Groups 2,3 same trigger: all bits at 0xffa4, 0xffa6 reads ones.
// [R9] Groups 2,3 differ: group 3 at 0xffa4 high, group 2 at 0xffa6 low.
// [R10] On group trigger, enabled pending low bits copy into port A.
// [R11] On group trigger, enabled pending high bits copy into port B.
// [R12] Port A bits enabled for transfer ignore software writes, stay readable.
// [R13] Two-bit field per group picks timer channel; resets to 0xff.
// [R14] Compare match is a one-cycle pulse; transfer in that same cycle.
module ppu_pattern_transfer (
    input wire pclk, // System clock, 250 MHz
    input wire presetn, // Asynchronous reset, active low
    input wire hw_standby, // Hardware standby request, returns registers to reset values
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB direction, high for write
    input wire [31:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data, low byte used
    input wire [3:0] pstrb, // APB byte strobes, lane 0 used
    output reg [31:0] prdata, // APB read data, registered
    output reg pready, // APB ready, registered
    output reg pslverr, // APB error on unmapped address
    input wire [3:0] compare_match, // Timer channel 3..0 match pulses
    output reg [7:0] port_a_out, // Pattern pins 7..0
    output reg [7:0] port_b_out // Pattern pins 15..8
);

    reg [7:0] pend_low_q;
    reg [7:0] pend_high_q;
    reg [7:0] en_low_q;
    reg [7:0] en_high_q;
    reg [7:0] trig_sel_q;
    reg [7:0] port_a_q;
    reg [7:0] port_b_q;
    reg [7:0] rd_byte;
    reg rd_hit;
    reg [3:0] grp_fire;
    reg [7:0] fire_a;
    reg [7:0] fire_b;
    reg [7:0] pend_low_d;
    reg [7:0] pend_high_d;
    reg [7:0] port_a_d;
    reg [7:0] port_b_d;
    reg [7:0] en_low_d;
    reg [7:0] en_high_d;
    reg [7:0] trig_sel_d;
    wire [15:0] addr_lo;
    wire acc;
    wire wr;
    wire wr_pend_low;
    wire wr_pend_g0;
    wire wr_pend_high;
    wire wr_pend_g2;
    wire wr_en_low;
    wire wr_en_high;
    wire wr_trig_sel;
    wire wr_port_a;
    wire wr_port_b;
    wire same_01;
    wire same_23;
    wire [1:0] sel0;
    wire [1:0] sel1;
    wire [1:0] sel2;
    wire [1:0] sel3;

    // Decode of one APB access; a write lands once, on the first access-phase
    // edge with pready low, so the answer always takes one wait state
    assign addr_lo = paddr[15:0];
    assign acc = psel && penable && !pready;
    assign wr = acc && pwrite && pstrb[0];

    // Per-register write strobes, one per decoded address
    assign wr_pend_low = wr && (addr_lo == `PPU_OFF_PEND_LOW);
    assign wr_pend_g0 = wr && (addr_lo == `PPU_OFF_PEND_G0);
    assign wr_pend_high = wr && (addr_lo == `PPU_OFF_PEND_HIGH);
    assign wr_pend_g2 = wr && (addr_lo == `PPU_OFF_PEND_G2);
    assign wr_en_low = wr && (addr_lo == `PPU_OFF_EN_LOW);
    assign wr_en_high = wr && (addr_lo == `PPU_OFF_EN_HIGH);
    assign wr_trig_sel = wr && (addr_lo == `PPU_OFF_TRIG_SEL);
    assign wr_port_a = wr && (addr_lo == `PPU_OFF_PORT_A);
    assign wr_port_b = wr && (addr_lo == `PPU_OFF_PORT_B);

    // Group trigger selection fields
    assign sel0 = trig_sel_q[`PPU_SEL_G0_LSB +: 2];
    assign sel1 = trig_sel_q[`PPU_SEL_G1_LSB +: 2];
    assign sel2 = trig_sel_q[`PPU_SEL_G2_LSB +: 2];
    assign sel3 = trig_sel_q[`PPU_SEL_G3_LSB +: 2];

    // Paired groups share one byte view when their fields match
    assign same_01 = (sel0 == sel1);
    assign same_23 = (sel2 == sel3);

    // Each group watches the compare-match channel its field selects
    always @* begin
        grp_fire[0] = compare_match[sel0]; // see [R13] see [R14]
        grp_fire[1] = compare_match[sel1]; // see [R13] see [R14]
        grp_fire[2] = compare_match[sel2]; // see [R13] see [R14]
        grp_fire[3] = compare_match[sel3]; // see [R13] see [R14]
    end

    // Per-bit transfer masks: only enabled bits of a firing group move
    always @* begin
        fire_a = {{4{grp_fire[1]}}, {4{grp_fire[0]}}} & en_low_q;
        fire_b = {{4{grp_fire[3]}}, {4{grp_fire[2]}}} & en_high_q;
    end

    // Next value of the pending low byte, address view per pairing
    always @* begin
        pend_low_d = pend_low_q;
        if (wr_pend_low) begin
            if (same_01) begin
                pend_low_d = pwdata[7:0]; // see [R3] see [R6]
            end else begin
                pend_low_d[7:4] = pwdata[7:4]; // see [R7]
            end
        end
        if (wr_pend_g0 && !same_01) begin
            pend_low_d[3:0] = pwdata[3:0]; // see [R7]
        end
    end

    // Next value of the pending high byte, address view per pairing
    always @* begin
        pend_high_d = pend_high_q;
        if (wr_pend_high) begin
            if (same_23) begin
                pend_high_d = pwdata[7:0]; // see [R4] see [R8]
            end else begin
                pend_high_d[7:4] = pwdata[7:4]; // see [R9]
            end
        end
        if (wr_pend_g2 && !same_23) begin
            pend_high_d[3:0] = pwdata[3:0]; // see [R9]
        end
    end

    // Next values of enables and trigger select, plain read/write bytes
    always @* begin
        en_low_d = en_low_q;
        en_high_d = en_high_q;
        trig_sel_d = trig_sel_q;
        if (wr_en_low) begin
            en_low_d = pwdata[7:0];
        end
        if (wr_en_high) begin
            en_high_d = pwdata[7:0];
        end
        if (wr_trig_sel) begin
            trig_sel_d = pwdata[7:0]; // see [R13]
        end
    end

    // Port values: software writes only unlocked bits, transfer wins
    always @* begin
        port_a_d = port_a_q;
        port_b_d = port_b_q;
        if (wr_port_a) begin
            port_a_d = (port_a_q & en_low_q) | (pwdata[7:0] & ~en_low_q);
        end // see [R12]
        if (wr_port_b) begin
            port_b_d = (port_b_q & en_high_q) | (pwdata[7:0] & ~en_high_q);
        end // see [R2]
        port_a_d = (port_a_d & ~fire_a) | (pend_low_q & fire_a); // see [R10]
        port_b_d = (port_b_d & ~fire_b) | (pend_high_q & fire_b); // see [R11]
    end

    // Read mux; reserved nibbles and empty views read as ones
    always @* begin
        rd_byte = `PPU_RSVD_BYTE;
        rd_hit = 1'b1;
        case (addr_lo)
            `PPU_OFF_PEND_LOW: begin
                rd_byte = same_01 ? pend_low_q
                        : {pend_low_q[7:4], 4'hf}; // see [R6] see [R7]
            end
            `PPU_OFF_PEND_G0: begin
                rd_byte = same_01 ? `PPU_RSVD_BYTE
                        : {4'hf, pend_low_q[3:0]}; // see [R6] see [R7]
            end
            `PPU_OFF_PEND_HIGH: begin
                rd_byte = same_23 ? pend_high_q
                        : {pend_high_q[7:4], 4'hf}; // see [R8] see [R9]
            end
            `PPU_OFF_PEND_G2: begin
                rd_byte = same_23 ? `PPU_RSVD_BYTE
                        : {4'hf, pend_high_q[3:0]}; // see [R8] see [R9]
            end
            `PPU_OFF_EN_LOW: rd_byte = en_low_q;
            `PPU_OFF_EN_HIGH: rd_byte = en_high_q;
            `PPU_OFF_TRIG_SEL: rd_byte = trig_sel_q;
            `PPU_OFF_PORT_A: rd_byte = port_a_q; // see [R12]
            `PPU_OFF_PORT_B: rd_byte = port_b_q; // see [R2]
            default: rd_hit = 1'b0;
        endcase
    end

    // Pending bytes; hardware standby clears them, soft standby keeps them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_low_q <= `PPU_RST_PEND;
            pend_high_q <= `PPU_RST_PEND;
        end else if (hw_standby) begin
            pend_low_q <= `PPU_RST_PEND; // see [R5]
            pend_high_q <= `PPU_RST_PEND; // see [R5]
        end else begin
            pend_low_q <= pend_low_d;
            pend_high_q <= pend_high_d;
        end
    end

    // Transfer enables; hardware standby clears them like reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_low_q <= `PPU_RST_EN;
            en_high_q <= `PPU_RST_EN;
        end else if (hw_standby) begin
            en_low_q <= `PPU_RST_EN; // see [R5]
            en_high_q <= `PPU_RST_EN; // see [R5]
        end else begin
            en_low_q <= en_low_d;
            en_high_q <= en_high_d;
        end
    end

    // Trigger select; every group starts on the last channel
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_sel_q <= `PPU_RST_TRIG_SEL; // see [R13]
        end else if (hw_standby) begin
            trig_sel_q <= `PPU_RST_TRIG_SEL; // see [R13]
        end else begin
            trig_sel_q <= trig_sel_d;
        end
    end

    // Port registers; standby clears them so the pins restart at zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_q <= `PPU_RST_PORT;
            port_b_q <= `PPU_RST_PORT; // see [R1]
        end else if (hw_standby) begin
            port_a_q <= `PPU_RST_PORT;
            port_b_q <= `PPU_RST_PORT;
        end else begin
            port_a_q <= port_a_d;
            port_b_q <= port_b_d; // see [R1]
        end
    end

    // Ready pulses one cycle after the first access-phase edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= acc;
        end
    end

    // Error pulses with ready when no register sits at the address
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= acc && !rd_hit;
        end
    end

    // Read data is captured with ready and held until the next read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (acc && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // Pattern pins 7..0; standby clears them in step with the register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_out <= `PPU_RST_PORT;
        end else if (hw_standby) begin
            port_a_out <= `PPU_RST_PORT;
        end else begin
            port_a_out <= port_a_d; // see [R10]
        end
    end

    // Pattern pins 15..8; standby clears them in step with the register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_out <= `PPU_RST_PORT;
        end else if (hw_standby) begin
            port_b_out <= `PPU_RST_PORT; // see [R1]
        end else begin
            port_b_out <= port_b_d; // see [R11]
        end
    end

endmodule

// ---- test/ppu_timer_model.sv ----
// Timer unit stand-in that emits compare-match pulses
`timescale 1ns/10ps
module ppu_timer_model (
    input wire pclk, // System clock
    input wire presetn, // Reset, active low
    input wire fire, // Request one pulse
    input wire [1:0] chan, // Channel to pulse
    output reg [3:0] compare_match // One-cycle match pulses
);
    // Single-cycle pulse on the chosen channel, quiet otherwise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) compare_match <= 4'h0;
        else compare_match <= fire ? (4'h1 << chan) : 4'h0;
    end
endmodule

// ---- test/ppu_chk.sv ----
// Port-level checker for the pattern transfer block
`timescale 1ns/10ps
module ppu_chk (
    input wire pclk, // System clock
    input wire presetn, // Reset, active low
    input wire hw_standby, // Hardware standby
    input wire psel, // Bus select
    input wire penable, // Bus access phase
    input wire pwrite, // Bus direction
    input wire [31:0] paddr, // Bus address
    input wire [31:0] prdata, // Bus read data
    input wire pready, // Bus ready
    input wire pslverr, // Bus error
    input wire [3:0] compare_match, // Trigger pulses
    input wire [7:0] port_a_out, // Pattern pins 7..0
    input wire [7:0] port_b_out // Pattern pins 15..8
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Address decode and quiet-cycle helpers
    wire [15:0] a = paddr[15:0];
    wire mapped = (a >= 16'hffa1 && a <= 16'hffa7) || a == 16'hffd3
        || a == 16'hffd6;
    wire quiet = ~|compare_match & ~hw_standby & ~(psel & penable & pwrite);
    ready_wait_a: assert property ($rose(penable) && psel |=>
        pready ##1 !pready) else $error("ready timing wrong");
    ready_only_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready && !mapped)
        else $error("error without cause");
    unmapped_a: assert property (pready && !pwrite && !mapped |->
        pslverr && prdata[7:0] == 8'hff) else $error("unmapped read wrong");
    mapped_ok_a: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    standby_clr_a: assert property (hw_standby |=>
        port_a_out == 8'h00 && port_b_out == 8'h00)
        else $error("standby left pins set");
    pins_hold_a: assert property (quiet |=>
        $stable(port_a_out) && $stable(port_b_out))
        else $error("pins moved without cause");
    cover property (pready && pslverr);
    cover property (|compare_match ##1 $changed(port_a_out));
    cover property (hw_standby);
endmodule
bind ppu_pattern_transfer ppu_chk u_chk (.pclk(pclk), .presetn(presetn),
    .hw_standby(hw_standby), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_match(compare_match),
    .port_a_out(port_a_out), .port_b_out(port_b_out));

// ---- test/testbench.sv ----
// Self-checking bench for the pattern transfer block
`timescale 1ns/10ps
module testbench;
    reg pclk = 0, presetn = 0, hw_standby = 0, psel = 0, penable = 0;
    reg pwrite = 0, fire = 0, e;
    reg [1:0] chan = 0;
    reg [31:0] paddr = 0, pwdata = 0;
    reg [7:0] r;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [3:0] cm;
    wire [7:0] pa, pb;
    integer error_cnt = 0, n_compared = 0, cyc = 0;
    ppu_timer_model tmr (.pclk(pclk), .presetn(presetn), .fire(fire),
        .chan(chan), .compare_match(cm));
    ppu_pattern_transfer dut (.pclk(pclk), .presetn(presetn),
        .hw_standby(hw_standby), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .compare_match(cm), .port_a_out(pa), .port_b_out(pb));
    initial forever #2 pclk = ~pclk;
    task wrap_up;
        begin
            $display("errors %0d compared %0d", error_cnt, n_compared);
            if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // Cut a hung run short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t timeout", $time);
            wrap_up;
        end
    end
    // Count one comparison and report a mismatch
    task chk(input [7:0] g, input [7:0] x);
        begin
            n_compared = n_compared + 1;
            if (g !== x) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t got %h want %h", $time, g, x);
            end
        end
    endtask
    // One bus transfer: setup, access, hold until ready
    task apb(input w, input [15:0] a, input [7:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= {16'h0, a};
            pwdata <= {24'h0, d};
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            r = prdata[7:0];
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Read one register and compare its byte
    task rd(input [15:0] a, input [7:0] x);
        begin
            apb(1'b0, a, 8'h00);
            chk(r, x);
        end
    endtask
    // Write one register byte
    task wr(input [15:0] a, input [7:0] d);
        begin
            apb(1'b1, a, d);
        end
    endtask
    // Timer pulse, then settle past the transfer edge
    task trig(input [1:0] c);
        begin
            @(posedge pclk);
            fire <= 1'b1;
            chan <= c;
            @(posedge pclk);
            fire <= 1'b0;
            @(posedge pclk);
            #1;
        end
    endtask
    // Reset values, empty views and an unmapped read
    task t_reset;
        begin
            rd(16'hffa1, 8'hff);
            rd(16'hffa5, 8'h00);
            rd(16'hffa2, 8'h00);
            rd(16'hffd6, 8'h00);
            rd(16'hffa7, 8'hff);
            rd(16'hffa6, 8'hff);
            rd(16'hffa0, 8'hff);
            chk({7'h0, e}, 8'h01);
        end
    endtask
    // Shared trigger: full views, transfer on channel 3, locked port bits
    task t_same;
        begin
            wr(16'hffa5, 8'ha5);
            wr(16'hffa7, 8'h00);
            rd(16'hffa7, 8'hff);
            rd(16'hffa5, 8'ha5);
            wr(16'hffa4, 8'h3c);
            wr(16'hffa6, 8'h00);
            rd(16'hffa4, 8'h3c);
            wr(16'hffa3, 8'h0f);
            wr(16'hffa2, 8'hf0);
            trig(2'd3);
            chk(pa, 8'h05);
            chk(pb, 8'h30);
            wr(16'hffd3, 8'hff);
            rd(16'hffd3, 8'hf5);
            wr(16'hffd6, 8'h00);
            rd(16'hffd6, 8'h30);
        end
    endtask
    // Split triggers: nibble views and per-group channels
    task t_split;
        begin
            wr(16'hffa1, 8'h1b);
            rd(16'hffa5, 8'haf);
            rd(16'hffa7, 8'hf5);
            rd(16'hffa4, 8'h3f);
            rd(16'hffa6, 8'hfc);
            wr(16'hffa7, 8'h09);
            wr(16'hffa3, 8'hff);
            trig(2'd3);
            chk(pa, 8'hf9);
            trig(2'd2);
            chk(pa, 8'ha9);
            chk(pb, 8'h30);
        end
    endtask
    // Hardware standby returns registers and pins to reset values
    task t_stby;
        begin
            @(posedge pclk);
            hw_standby <= 1'b1;
            @(posedge pclk);
            hw_standby <= 1'b0;
            rd(16'hffa5, 8'h00);
            rd(16'hffa3, 8'h00);
            rd(16'hffa1, 8'hff);
            chk(pa, 8'h00);
            chk(pb, 8'h00);
        end
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset; t_same; t_split; t_stby;
        wrap_up;
    end
endmodule
